/* srr_fifo.sv */
`timescale 1ns/10ps

// Head word sits in an output register; the array holds DEPTH-1 words
module srr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int MD = DEPTH - 1;
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [MD];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  wire           push;
  wire           load;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == AW'(MD - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign push    = in_valid & in_ready;
  assign load    = (~out_valid | out_ready) & (cnt_r != '0);
  assign cnt_nxt = (AW+1)'(cnt_r + push - load);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r      <= '0;
      rp_r      <= '0;
      cnt_r     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      cnt_r    <= cnt_nxt;
      in_ready <= cnt_nxt < (AW+1)'(MD);
      if (push) begin
        mem[wp_r] <= in_data;
        wp_r      <= wrap_inc(wp_r);
      end
      if (load) begin
        out_data <= mem[rp_r];
        rp_r     <= wrap_inc(rp_r);
      end
      out_valid <= load | (out_valid & ~out_ready);
    end
  end
endmodule

/* srr_pkg.sv */
package srr_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OTF  = 3'b001,
    S_EVAL = 3'b010,
    S_RRD  = 3'b011,
    S_DBC  = 3'b100
  } srr_state_e;

  typedef logic [7:0] srr_byte_t;

endpackage

/* srr_recovery_top.sv */
`timescale 1ns/10ps
`include "srr_regs.svh"

module srr_recovery_top #(
  parameter int unsigned OTF_CYC = `SRR_OTF_US * `SRR_CLK_MHZ
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  cfg_awre,
  input  wire logic                  cfg_arre,
  input  wire logic                  cfg_rc,
  input  wire logic                  cfg_eer,
  input  wire logic                  cfg_dcr,
  input  wire logic                  cfg_limit_we,
  input  wire logic [7:0]            cfg_limit,
  input  wire logic                  med_valid,
  input  wire logic [7:0]            med_data,
  output logic                       med_ready,
  output logic                       host_valid,
  output logic [7:0]                 host_data,
  input  wire logic                  host_ready,
  input  wire logic                  syn_valid,
  input  wire logic [`SRR_SYN_W-1:0] calc_chk,
  input  wire logic [`SRR_SYN_W-1:0] stored_chk,
  input  wire logic                  otf_done,
  input  wire logic                  otf_ok,
  input  wire logic                  dbc_done,
  input  wire logic                  dbc_ok,
  input  wire logic [`SRR_CYL_W-1:0] cur_cyl,
  input  wire logic                  wr_fail,
  input  wire logic                  fact_defect,
  input  wire logic [`SRR_CYL_W-1:0] fact_cyl,
  output logic [7:0]                 reread_limit,
  output logic [7:0]                 retry_cnt,
  output logic                       busy,
  output logic                       reread_req,
  output logic                       otf_apply,
  output logic                       dbc_start,
  output logic                       stable_flag,
  output logic                       sector_ok,
  output logic                       sector_raw,
  output logic                       sector_unc,
  output logic                       realloc_req,
  output logic [`SRR_CYL_W-1:0]      spare_cyl,
  output logic [1:0]                 spare_slot,
  output logic                       realloc_inline,
  output logic                       realloc_bad,
  output logic                       spare_none
);

  ////////////////////////////////////////////////////////////////////////
  // State and datapath registers
  srr_pkg::srr_state_e   st_r;
  srr_pkg::srr_state_e   st_nxt;
  logic [`SRR_SYN_W-1:0] syn_r;
  logic [`SRR_SYN_W-1:0] prev_r;
  logic                  have_prev_r;
  logic                  otf_r;
  logic [15:0]           tmr_r;
  logic [7:0]            cnt_nxt;
  logic                  alc_r;
  logic                  alc_bad_r;
  logic                  rrq_nxt;
  logic                  ok_nxt;
  logic                  raw_nxt;
  logic                  unc_nxt;
  logic                  fix_nxt;
  logic                  dbs_nxt;
  logic                  alc_nxt;
  logic                  bad_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Decoding
  wire [`SRR_SYN_W-1:0] syn;
  wire                  syn_zero;
  wire                  stable;
  wire                  tmr_end;
  wire [7:0]            lim;
  wire                  more;
  wire                  in_g3;
  wire                  dbc_want;
  wire                  al_req;
  wire                  al_fact;
  wire [`SRR_CYL_W-1:0] al_cyl;
  wire                  al_bad;
  wire                  syn_take;

  assign syn      = calc_chk ^ stored_chk;
  assign syn_zero = ~|syn;
  assign syn_take = syn_valid & (st_r == srr_pkg::S_IDLE || st_r == srr_pkg::S_RRD);
  assign stable   = have_prev_r & (syn_r == prev_r);
  assign tmr_end  = tmr_r == 16'(OTF_CYC - 1);
  // Zero limit wins over the 24 re-read budget
  assign lim      = (reread_limit == 8'h00) ? 8'h00 :
                    cfg_arre ? `SRR_ARR_MAX : reread_limit;
  assign more     = retry_cnt < lim;
  assign in_g3    = retry_cnt > `SRR_G2_END;
  // Burst correction from the second group on under ARRE, else only on early correction
  assign dbc_want = cfg_arre ? (retry_cnt > `SRR_GRP_LEN) : cfg_eer;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = retry_cnt;
    rrq_nxt = 1'b0;
    ok_nxt  = 1'b0;
    raw_nxt = 1'b0;
    unc_nxt = 1'b0;
    fix_nxt = 1'b0;
    dbs_nxt = 1'b0;
    alc_nxt = 1'b0;
    bad_nxt = 1'b0;
    unique case (st_r)
      srr_pkg::S_IDLE: if (syn_valid) begin
        cnt_nxt = 8'h00;
        if (syn_zero) ok_nxt = 1'b1;
        else st_nxt = srr_pkg::S_OTF;
      end
      srr_pkg::S_RRD: if (syn_valid) begin
        if (syn_zero) begin
          ok_nxt = 1'b1;
          st_nxt = srr_pkg::S_IDLE;
        end else begin
          st_nxt = srr_pkg::S_OTF;
        end
      end
      srr_pkg::S_OTF: if (otf_done || tmr_end) st_nxt = srr_pkg::S_EVAL;
      srr_pkg::S_EVAL: begin
        st_nxt = srr_pkg::S_IDLE;
        if (otf_r) begin
          fix_nxt = 1'b1;
          ok_nxt  = 1'b1;
          alc_nxt = cfg_arre & in_g3;
        end else if (cfg_rc) begin
          unc_nxt = 1'b1;
        end else if (stable && dbc_want && cfg_dcr) begin
          raw_nxt = 1'b1;
        end else if (stable && dbc_want) begin
          dbs_nxt = 1'b1;
          st_nxt  = srr_pkg::S_DBC;
        end else if (more) begin
          rrq_nxt = 1'b1;
          cnt_nxt = retry_cnt + 8'h01;
          st_nxt  = srr_pkg::S_RRD;
        end else begin
          unc_nxt = 1'b1;
          alc_nxt = cfg_arre;
          bad_nxt = cfg_arre;
        end
      end
      srr_pkg::S_DBC: if (dbc_done) begin
        st_nxt = srr_pkg::S_IDLE;
        if (dbc_ok) begin
          ok_nxt  = 1'b1;
          alc_nxt = 1'b1;
        end else if (cfg_arre && in_g3) begin
          unc_nxt = 1'b1;
          alc_nxt = 1'b1;
          bad_nxt = 1'b1;
        end else if (more) begin
          rrq_nxt = 1'b1;
          cnt_nxt = retry_cnt + 8'h01;
          st_nxt  = srr_pkg::S_RRD;
        end else begin
          unc_nxt = 1'b1;
          alc_nxt = cfg_arre;
          bad_nxt = cfg_arre;
        end
      end
      default: st_nxt = srr_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= srr_pkg::S_IDLE;
      retry_cnt   <= 8'h00;
      busy        <= 1'b0;
      reread_req  <= 1'b0;
      otf_apply   <= 1'b0;
      dbc_start   <= 1'b0;
      stable_flag <= 1'b0;
      sector_ok   <= 1'b0;
      sector_raw  <= 1'b0;
      sector_unc  <= 1'b0;
      alc_r       <= 1'b0;
      alc_bad_r   <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      retry_cnt   <= cnt_nxt;
      busy        <= st_nxt != srr_pkg::S_IDLE;
      reread_req  <= rrq_nxt;
      otf_apply   <= fix_nxt;
      dbc_start   <= dbs_nxt;
      stable_flag <= (st_r == srr_pkg::S_EVAL) & stable;
      sector_ok   <= ok_nxt;
      sector_raw  <= raw_nxt;
      sector_unc  <= unc_nxt;
      alc_r       <= alc_nxt;
      alc_bad_r   <= bad_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Syndrome history and decision timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syn_r       <= '0;
      prev_r      <= '0;
      have_prev_r <= 1'b0;
    end else if (syn_take) begin
      prev_r      <= syn_r;
      syn_r       <= syn;
      have_prev_r <= st_r == srr_pkg::S_RRD;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= 16'h0000;
      otf_r <= 1'b0;
    end else if (st_r == srr_pkg::S_OTF) begin
      tmr_r <= tmr_r + 16'h0001;
      otf_r <= otf_done & otf_ok;
    end else begin
      tmr_r <= 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reread_limit <= `SRR_LIMIT_RST;
    else if (cfg_limit_we) reread_limit <= cfg_limit;
  end

  ////////////////////////////////////////////////////////////////////////
  // Spare allocation: read recovery first, then factory, then write
  assign al_req  = alc_r | fact_defect | (wr_fail & cfg_awre);
  assign al_fact = ~alc_r & fact_defect;
  assign al_cyl  = al_fact ? fact_cyl : cur_cyl;
  assign al_bad  = alc_r & alc_bad_r;

  srr_spare_alloc u_alloc (
    .clk      (clk),
    .rst_n    (rst_n),
    .req      (al_req),
    .cyl      (al_cyl),
    .fact     (al_fact),
    .bad      (al_bad),
    .g_valid  (realloc_req),
    .g_cyl    (spare_cyl),
    .g_slot   (spare_slot),
    .g_inline (realloc_inline),
    .g_bad    (realloc_bad),
    .g_none   (spare_none)
  );

  ////////////////////////////////////////////////////////////////////////
  // Data path: the stream never waits on recovery decisions
  srr_fifo #(
    .W     (8),
    .DEPTH (8)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (med_valid),
    .in_data   (med_data),
    .in_ready  (med_ready),
    .out_valid (host_valid),
    .out_data  (host_data),
    .out_ready (host_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  otf_bound_a: assert property ((st_r == srr_pkg::S_OTF) |-> tmr_r < 16'(OTF_CYC))
    else $error("fly decision overran its time");
  clean_pass_a: assert property (st_r == srr_pkg::S_RRD && syn_valid && syn_zero
    |=> sector_ok && !reread_req)
    else $error("clean re-read not transferred");
  fly_fix_a: assert property (st_r == srr_pkg::S_EVAL && otf_r
    |=> otf_apply && sector_ok && !reread_req && !dbc_start)
    else $error("fly-correctable sector not passed on");
  limit_zero_a: assert property (reread_req |-> $past(reread_limit) != 8'h00)
    else $error("re-read issued with zero limit");
  budget_cap_a: assert property (reread_req && $past(cfg_arre) |-> retry_cnt <= 8'h18)
    else $error("re-read budget exceeded");
  cont_skip_a: assert property (st_r == srr_pkg::S_EVAL && cfg_rc && !otf_r
    |=> sector_unc && !reread_req && !dbc_start)
    else $error("continuous read still recovering");
  raw_nodbc_a: assert property (dbc_start |-> !$past(cfg_dcr))
    else $error("burst correction while disabled");
  group_one_a: assert property (dbc_start && $past(cfg_arre)
    |-> $past(retry_cnt) > 8'h08)
    else $error("burst correction in first group");
  reread_first_a: assert property (dbc_start |->
    $past(stable) && $past(retry_cnt) != 8'h00)
    else $error("burst correction before re-read");
  stable_flag_a: assert property (stable_flag |->
    $past(syn_r == prev_r) && $past(have_prev_r))
    else $error("stable flag without equal syndromes");
  unc_status_a: assert property (st_r == srr_pkg::S_EVAL && !otf_r && !cfg_rc && !more
    && !(stable && dbc_want) |=> sector_unc && !sector_ok)
    else $error("exhausted sector not reported");
  spent_mark_a: assert property (st_r == srr_pkg::S_EVAL && !otf_r && !cfg_rc && !more
    && !(stable && dbc_want) && cfg_arre |=> alc_r && alc_bad_r)
    else $error("exhausted sector not spared as bad");
  // A granted spare or an empty pool must follow one cycle after the request
  grown_realloc_a: assert property (st_r == srr_pkg::S_DBC && dbc_done && dbc_ok
    |=> alc_r && !alc_bad_r ##1 ((realloc_req && !realloc_bad) || spare_none))
    else $error("corrected sector not reallocated");
  failed_mark_a: assert property (st_r == srr_pkg::S_DBC && dbc_done && !dbc_ok
    && cfg_arre && in_g3 |=> sector_unc && alc_r && alc_bad_r)
    else $error("failed burst correction not marked");

  clean_reread_c: cover property (reread_req ##[1:50] sector_ok);
  dbc_run_c: cover property (dbc_start ##[1:50] realloc_req);
  bad_spare_c: cover property (realloc_req && realloc_bad);
  unc_end_c: cover property (reread_req ##[1:200] sector_unc);
  raw_end_c: cover property (stable_flag && sector_raw);

endmodule

/* srr_recovery_top_tb_top.sv */
`timescale 1ns/10ps
`include "srr_regs.svh"

module srr_recovery_top_tb_top;
  logic                  clk, rst_n, cfg_awre, cfg_arre, cfg_rc, cfg_eer, cfg_dcr;
  logic                  cfg_limit_we, med_valid, med_ready, host_valid, host_ready;
  logic                  syn_valid, otf_done, otf_ok, dbc_done, dbc_ok, wr_fail;
  logic                  fact_defect, busy, reread_req, otf_apply, dbc_start;
  logic                  stable_flag, sector_ok, sector_raw, sector_unc, realloc_req;
  logic                  realloc_inline, realloc_bad, spare_none, src_en, hold, rbad;
  logic [7:0]            cfg_limit, med_data, host_data, reread_limit, retry_cnt, lim;
  logic [`SRR_SYN_W-1:0] calc_chk, stored_chk, stab;
  logic [`SRR_CYL_W-1:0] cur_cyl, fact_cyl, spare_cyl;
  logic [1:0]            spare_slot;
  int                    tx_cnt, rx_cnt, bad_cnt, err_total, n_checks;
  int                    rr, nd, nst, napp, nrl, res, i;

  srr_recovery_top #(.OTF_CYC(20)) dut (
    .clk, .rst_n, .cfg_awre, .cfg_arre, .cfg_rc, .cfg_eer, .cfg_dcr, .cfg_limit_we,
    .cfg_limit, .med_valid, .med_data, .med_ready, .host_valid, .host_data,
    .host_ready, .syn_valid, .calc_chk, .stored_chk, .otf_done, .otf_ok, .dbc_done,
    .dbc_ok, .cur_cyl, .wr_fail, .fact_defect, .fact_cyl, .reread_limit, .retry_cnt,
    .busy, .reread_req, .otf_apply, .dbc_start, .stable_flag, .sector_ok, .sector_raw,
    .sector_unc, .realloc_req, .spare_cyl, .spare_slot, .realloc_inline, .realloc_bad,
    .spare_none
  );

  srr_stream_model peer (
    .clk, .rst_n, .src_en, .hold, .med_ready, .host_valid, .host_data, .med_valid,
    .med_data, .host_ready, .tx_cnt, .rx_cnt, .bad_cnt
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic int budget(input logic arre, input logic [7:0] l);
    return (l == 8'h00) ? 0 : (arre ? 24 : int'(l));
  endfunction

  // Read k of a sector: clean from cl on, repeating from st on, else unique
  function automatic logic [159:0] syn_of(input int k, input int st, input int cl);
    if (k >= cl) return '0;
    if (k >= st) return stab;
    return {$urandom, $urandom, $urandom, $urandom, 24'h000000, 8'h80 | k[7:0]};
  endfunction

  task automatic set_lim(input logic [7:0] v);
    cfg_limit = v;
    cfg_limit_we = 1'b1;
    @(negedge clk);
    cfg_limit_we = 1'b0;
    @(negedge clk);
  endtask

  // Plays the read channel and correction engines for one sector
  task automatic run_sector(input int st, input int cl, input logic oo, input logic dk);
    int k;
    int w;
    int fin;
    int cyc;
    logic sv;
    logic [159:0] s;
    rr = 0;
    nd = 0;
    nst = 0;
    napp = 0;
    nrl = 0;
    res = 0;
    rbad = 1'b0;
    k = 0;
    fin = -1;
    cyc = 0;
    s = syn_of(0, st, cl);
    calc_chk = {$urandom, $urandom, $urandom, $urandom, $urandom};
    stored_chk = calc_chk ^ s;
    syn_valid = 1'b1;
    w = (s != '0) ? 2 : 0;
    otf_ok = oo;
    dbc_ok = dk;
    while (fin != 0 && cyc < 3000) begin
      @(negedge clk);
      cyc++;
      sv = 1'b0;
      if (fin > 0) fin--;
      otf_done = (w == 1);
      if (w > 0) w--;
      dbc_done = (dbc_start === 1'b1);
      if (dbc_start === 1'b1) nd++;
      if (stable_flag === 1'b1) nst++;
      if (otf_apply === 1'b1 && sector_ok === 1'b1) napp++;
      if (realloc_req === 1'b1) begin
        nrl++;
        rbad = realloc_bad;
      end
      if (reread_req === 1'b1) begin
        rr++;
        k++;
        s = syn_of(k, st, cl);
        calc_chk = {$urandom, $urandom, $urandom, $urandom, $urandom};
        stored_chk = calc_chk ^ s;
        sv = 1'b1;
        w = (s != '0) ? 2 : 0;
      end
      if (res == 0 && fin < 0) begin
        if (sector_ok === 1'b1) res = 1;
        else if (sector_raw === 1'b1) res = 2;
        else if (sector_unc === 1'b1) res = 3;
        if (res != 0) fin = 4;
      end
      syn_valid = sv;
    end
    check(cyc < 3000, 1);
    check(retry_cnt, rr);
    check(busy, 0);
  endtask

  // Factory defect (f=1) or failed write (f=0) at cylinder c
  task automatic alloc(input logic f, input logic [3:0] c, input logic [3:0] ec,
                       input logic [1:0] es, input logic ei, input logic er);
    fact_defect = f;
    wr_fail = !f;
    fact_cyl = c;
    cur_cyl = c;
    @(negedge clk);
    fact_defect = 1'b0;
    wr_fail = 1'b0;
    // The grant pulse stands in the cycle right after the request edge
    check(realloc_req, er);
    check(spare_none, 1'b0);
    if (er) begin
      check(spare_cyl, ec);
      check(spare_slot, es);
      check(realloc_inline, ei);
    end
    @(negedge clk);
  endtask

  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 0;
    rst_n = 0;
    cfg_awre = 0;
    cfg_arre = 0;
    cfg_rc = 0;
    cfg_eer = 0;
    cfg_dcr = 0;
    cfg_limit_we = 0;
    cfg_limit = 8'h08;
    syn_valid = 0;
    otf_done = 0;
    otf_ok = 0;
    dbc_done = 0;
    dbc_ok = 0;
    wr_fail = 0;
    fact_defect = 0;
    calc_chk = '0;
    stored_chk = '0;
    cur_cyl = 4'h1;
    fact_cyl = 4'h0;
    src_en = 1;
    hold = 1;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'h3D30));
    stab = {$urandom, $urandom, $urandom, $urandom, 24'h000000, 8'h5A};
    repeat (20) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    check(reread_limit, `SRR_LIMIT_RST);
    check(busy, 0);
    repeat (20) @(negedge clk);
    check(med_ready, 0);
    check(tx_cnt, 8);
    hold = 0;
    run_sector(255, 0, 0, 0);
    check(res, 1);
    check(rr, 0);
    run_sector(255, 255, 1, 0);
    check(res, 1);
    check(napp, 1);
    check(rr, 0);
    run_sector(255, 3, 0, 0);
    check(res, 1);
    check(rr, 3);
    check(nd, 0);
    run_sector(255, 255, 0, 0);
    check(rr, budget(0, 8'h08));
    check(res, 3);
    check(nrl, 0);
    lim = 8'($urandom_range(7, 1));
    set_lim(lim);
    check(reread_limit, lim);
    run_sector(255, 255, 0, 0);
    check(rr, budget(0, lim));
    check(res, 3);
    set_lim(8'h00);
    run_sector(255, 255, 0, 0);
    check(rr, 0);
    check(res, 3);
    set_lim(8'h08);
    cfg_rc = 1;
    run_sector(255, 255, 0, 0);
    check(rr, 0);
    check(res, 3);
    cfg_rc = 0;
    cfg_eer = 1;
    cur_cyl = 4'h6;
    run_sector(0, 255, 0, 1);
    check(nst > 0, 1);
    check(nd, 1);
    check(rr, 1);
    check(res, 1);
    check(nrl, 1);
    check(rbad, 0);
    cfg_dcr = 1;
    run_sector(0, 255, 0, 1);
    check(res, 2);
    check(nd, 0);
    cfg_dcr = 0;
    cfg_eer = 0;
    cfg_arre = 1;
    cur_cyl = 4'h7;
    run_sector(0, 255, 0, 1);
    check(rr, 9);
    check(nd, 1);
    check(res, 1);
    check(nrl, 1);
    cur_cyl = 4'h8;
    run_sector(255, 255, 0, 0);
    check(rr, budget(1, 8'h08));
    check(res, 3);
    check(nrl, 1);
    check(rbad, 1);
    cur_cyl = 4'h9;
    run_sector(16, 255, 0, 0);
    check(rr, 17);
    check(nrl, 1);
    check(rbad, 1);
    check(res, 3);
    cfg_arre = 0;
    for (i = 0; i < 5; i++) begin
      alloc(1, 4'hE, (i < 4) ? 4'hE : 4'hD, (i < 4) ? i[1:0] : 2'h0, i < 4, 1);
    end
    alloc(0, 4'hC, 4'hC, 2'h0, 0, 0);
    cfg_awre = 1;
    alloc(0, 4'hC, 4'hC, 2'h0, 0, 1);
    // Ten of the 64 spares are taken by now; the 55th request finds none
    for (i = 0; i < 55; i++) begin
      fact_defect = 1'b1;
      fact_cyl = 4'h0;
      @(negedge clk);
      fact_defect = 1'b0;
      check({realloc_req, spare_none}, (i < 54) ? 2'b10 : 2'b01);
      @(negedge clk);
    end
    src_en = 0;
    for (i = 0; i < 500 && (rx_cnt != tx_cnt || host_valid !== 1'b0); i++) begin
      @(negedge clk);
    end
    check(rx_cnt, tx_cnt);
    check(bad_cnt, 0);
    check(host_valid, 0);
    wrap_up();
  end
endmodule

/* srr_regs.svh */
`ifndef SRR_REGS_SVH
`define SRR_REGS_SVH

////////////////////////////////////////////////////////////////////////
// Clock and decision time
`define SRR_CLK_MHZ    100
`define SRR_OTF_US     200

////////////////////////////////////////////////////////////////////////
// Syndrome layout: cross-check bytes in the low bits, ECC bytes above
`define SRR_XC_N       2
`define SRR_ECC_N      18
`define SRR_SYN_W      160

////////////////////////////////////////////////////////////////////////
// Re-read budget
`define SRR_GRP_LEN    8'h08
`define SRR_G2_END     8'h10
`define SRR_ARR_MAX    8'h18
`define SRR_LIMIT_RST  8'h08

////////////////////////////////////////////////////////////////////////
// Spare map
`define SRR_SPARES     4
`define SRR_NCYL       16
`define SRR_CYL_W      4

`endif

/* srr_spare_alloc.sv */
`timescale 1ns/10ps
`include "srr_regs.svh"

module srr_spare_alloc (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  req,
  input  wire logic [`SRR_CYL_W-1:0] cyl,
  input  wire logic                  fact,
  input  wire logic                  bad,
  output logic                       g_valid,
  output logic [`SRR_CYL_W-1:0]      g_cyl,
  output logic [1:0]                 g_slot,
  output logic                       g_inline,
  output logic                       g_bad,
  output logic                       g_none
);
  logic [2:0]            used_r [`SRR_NCYL];
  logic [`SRR_NCYL-1:0]  free;
  logic [`SRR_CYL_W:0]   hit;
  wire  [`SRR_CYL_W-1:0] pc;
  wire                   found;

  // Nearest cylinder with a free spare; a tie takes the lower cylinder
  function automatic logic [`SRR_CYL_W:0] nearest(
    input logic [`SRR_NCYL-1:0] fr,
    input logic [`SRR_CYL_W-1:0] c);
    logic [`SRR_CYL_W:0] r;
    int lo;
    int hi;
    r = '0;
    for (int d = `SRR_NCYL - 1; d >= 0; d--) begin
      hi = int'(c) + d;
      lo = int'(c) - d;
      if (hi < `SRR_NCYL && fr[hi]) r = {1'b1, hi[`SRR_CYL_W-1:0]};
      if (lo >= 0 && fr[lo]) r = {1'b1, lo[`SRR_CYL_W-1:0]};
    end
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < `SRR_NCYL; i++) begin
      free[i] = used_r[i] < 3'(`SRR_SPARES);
    end
  end

  assign hit   = nearest(free, cyl);
  assign found = hit[`SRR_CYL_W];
  assign pc    = hit[`SRR_CYL_W-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SRR_NCYL; i++) used_r[i] <= 3'h0;
      g_valid  <= 1'b0;
      g_cyl    <= '0;
      g_slot   <= 2'h0;
      g_inline <= 1'b0;
      g_bad    <= 1'b0;
      g_none   <= 1'b0;
    end else begin
      g_valid  <= req & found;
      g_none   <= req & ~found;
      g_cyl    <= pc;
      g_slot   <= used_r[pc][1:0];
      g_inline <= fact & (pc == cyl);
      g_bad    <= bad;
      if (req && found) used_r[pc] <= used_r[pc] + 3'h1;
    end
  end
endmodule

/* srr_stream_model.sv */
`timescale 1ns/10ps

// Media byte source and host byte sink; the sink stalls at random
module srr_stream_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       src_en,
  input  wire logic       hold,
  input  wire logic       med_ready,
  input  wire logic       host_valid,
  input  wire logic [7:0] host_data,
  output logic            med_valid,
  output logic [7:0]      med_data,
  output logic            host_ready,
  output int              tx_cnt,
  output int              rx_cnt,
  output int              bad_cnt
);
  logic took;

  initial begin
    med_valid = 1'b0;
    med_data = 8'h00;
    host_ready = 1'b0;
    tx_cnt = 0;
    rx_cnt = 0;
    bad_cnt = 0;
    took = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Handshakes complete at the rising edge
  always @(posedge clk) begin
    took <= med_valid & med_ready;
    if (host_valid && host_ready) begin
      if (host_data !== rx_cnt[7:0]) begin
        bad_cnt <= bad_cnt + 1;
      end
      rx_cnt <= rx_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Valid holds until taken; idle data toggles so stale bytes never match
  always @(negedge clk) begin
    if (took) begin
      tx_cnt = tx_cnt + 1;
    end
    if (!(med_valid && !took)) begin
      med_valid = src_en & rst_n;
    end
    med_data = med_valid ? tx_cnt[7:0] : ~med_data;
    host_ready = rst_n && !hold && ($urandom_range(3, 0) != 0);
  end
endmodule
